/* File: hdl/output_function_select.sv */
`timescale 1ns/100ps
`include "output_function_select_consts.svh"

module output_function_select #(
  parameter int MS_TICK_CYCLES    = `MS_TICK_CYC,
  parameter int INDEX_HOLD_CYCLES = `INDEX_HOLD_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  output var  logic [1:0]  BRESP,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  input  wire logic        RUNNING,
  input  wire logic        FORWARD_RUNNING,
  input  wire logic        REVERSE_RUNNING,
  input  wire logic        JOGGING,
  input  wire logic        DRIVE_FAULT,
  input  wire logic        FREQ_LEVEL_DETECT_ONE,
  input  wire logic        FREQ_LEVEL_DETECT_TWO,
  input  wire logic        FREQ_REACHED,
  input  wire logic        ZERO_SPEED_RUNNING,
  input  wire logic        UPPER_LIMIT,
  input  wire logic        LOWER_LIMIT,
  input  wire logic        READY_TO_RUN,
  input  wire logic        PRE_EXCITING,
  input  wire logic        OVERLOAD_PREALARM,
  input  wire logic        UNDERLOAD_PREALARM,
  input  wire logic        SEQ_STAGE_DONE,
  input  wire logic        SEQ_CYCLE_DONE,
  input  wire logic        COUNT_SET_REACHED,
  input  wire logic        COUNT_DESIGNATED_REACHED,
  input  wire logic        EXTERNAL_FAULT,
  input  wire logic        RUN_TIME_REACHED,
  input  wire logic        SERIAL_VIRTUAL_BIT,
  input  wire logic        FIELDBUS_VIRTUAL_BIT,
  input  wire logic        ETHERNET_VIRTUAL_BIT,
  input  wire logic        DC_BUS_ESTABLISHED,
  input  wire logic        INDEX_PULSE,
  input  wire logic        PULSE_SUPERPOSITION,
  input  wire logic        SAFE_TORQUE_OFF_FAULT,
  input  wire logic        POSITIONING_DONE,
  input  wire logic        SPINDLE_ZEROING_DONE,
  input  wire logic        SPINDLE_DIVISION_DONE,
  input  wire logic        SPEED_LIMITED,
  input  wire logic        INDUSTRIAL_ETH_VIRTUAL_BIT,
  input  wire logic        CONTROL_SWITCH_DONE,
  input  wire logic        CARD_COLLECTOR_ONE,
  input  wire logic        CARD_COLLECTOR_TWO,
  input  wire logic        CARD_FAST_TERMINAL,
  input  wire logic        CARD_RELAY_ONE,
  input  wire logic        CARD_RELAY_TWO,
  input  wire logic        CARD_RELAY_THREE,
  input  wire logic        CARD_RELAY_FOUR,
  input  wire logic        PULSE_TRAIN,
  output var  logic        COLLECTOR_OUTPUT_ONE,
  output var  logic        FAST_PULSE_TERMINAL,
  output var  logic        RELAY_OUTPUT_ONE,
  output var  logic        RELAY_OUTPUT_TWO,
  output var  logic        IRQ
);

  localparam int MS_W  = $clog2(MS_TICK_CYCLES + 1);
  localparam int IDX_W = $clog2(INDEX_HOLD_CYCLES + 1);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic pick(
    input output_function_select_pkg::func_code_t code,
    input logic [63:0]                             src);
    pick = (code < 8'h40) ? src[code[5:0]] : 1'b0;
  endfunction : pick

  function automatic output_function_select_pkg::delay_ms_t clamp_ms(
    input logic [15:0] value);
    clamp_ms = (value > `DELAY_MAX_MS) ? `DELAY_MAX_MS : value;
  endfunction : clamp_ms

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  output_function_select_pkg::func_code_t fast_type;
  output_function_select_pkg::func_code_t col_src;
  output_function_select_pkg::func_code_t fast_src;
  output_function_select_pkg::func_code_t relay1_src;
  output_function_select_pkg::func_code_t relay2_src;
  output_function_select_pkg::term_vec_t  polarity;
  output_function_select_pkg::func_code_t card_en;
  output_function_select_pkg::delay_ms_t  on_delay;
  output_function_select_pkg::delay_ms_t  off_delay;
  output_function_select_pkg::term_vec_t  irq_status;
  output_function_select_pkg::term_vec_t  irq_mask;
  output_function_select_pkg::fast_role_t fast_role;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_hold;
  logic        w_hold;
  logic [MS_W-1:0]  ms_cnt;
  logic             ms_tick;
  logic [IDX_W-1:0] index_cnt;
  logic             fast_level;
  output_function_select_pkg::delay_ms_t dly_cnt;

  // ---------------------------------------------------------------
  // source table
  // ---------------------------------------------------------------
  wire        index_active = (index_cnt != '0);
  wire        card_on      = (card_en == 8'h01);
  wire [6:0]  card_bits    = {CARD_RELAY_FOUR, CARD_RELAY_THREE,
                              CARD_RELAY_TWO, CARD_RELAY_ONE,
                              CARD_FAST_TERMINAL, CARD_COLLECTOR_TWO,
                              CARD_COLLECTOR_ONE} & {7{card_on}};
  wire [63:0] source_bits;

  assign source_bits[15:0] = {UNDERLOAD_PREALARM, OVERLOAD_PREALARM,
                              PRE_EXCITING, READY_TO_RUN, LOWER_LIMIT,
                              UPPER_LIMIT, ZERO_SPEED_RUNNING, FREQ_REACHED,
                              FREQ_LEVEL_DETECT_TWO, FREQ_LEVEL_DETECT_ONE,
                              DRIVE_FAULT, JOGGING, REVERSE_RUNNING,
                              FORWARD_RUNNING, RUNNING, 1'b0};
  assign source_bits[31:16] = {SPINDLE_ZEROING_DONE, POSITIONING_DONE,
                               SAFE_TORQUE_OFF_FAULT, PULSE_SUPERPOSITION,
                               index_active, DC_BUS_ESTABLISHED,
                               ETHERNET_VIRTUAL_BIT, FIELDBUS_VIRTUAL_BIT,
                               SERIAL_VIRTUAL_BIT, RUN_TIME_REACHED, 1'b0,
                               EXTERNAL_FAULT, COUNT_DESIGNATED_REACHED,
                               COUNT_SET_REACHED, SEQ_CYCLE_DONE,
                               SEQ_STAGE_DONE};
  assign source_bits[47:32] = {card_bits, 4'h0, CONTROL_SWITCH_DONE, 1'b0,
                               INDUSTRIAL_ETH_VIRTUAL_BIT, SPEED_LIMITED,
                               SPINDLE_DIVISION_DONE};
  assign source_bits[63:48] = 16'h0000;

  // ---------------------------------------------------------------
  // terminal selection
  // ---------------------------------------------------------------
  // each terminal looks the table up on its own
  wire col_target    = pick(col_src, source_bits) ^ polarity[`TERM_COL];
  wire fast_target   = pick(fast_src, source_bits) ^ polarity[`TERM_FAST];
  wire relay1_target = pick(relay1_src, source_bits)
                       ^ polarity[`TERM_RELAY1];
  wire relay2_target = pick(relay2_src, source_bits)
                       ^ polarity[`TERM_RELAY2];
  assign fast_role = (fast_type == 8'h00) ?
                     output_function_select_pkg::FAST_PULSE :
                     output_function_select_pkg::FAST_SWITCH;
  wire fast_hold_ms  = fast_target ? (dly_cnt >= on_delay)
                                   : (dly_cnt >= off_delay);
  wire next_fast     = (fast_role == output_function_select_pkg::FAST_PULSE)
                       ? PULSE_TRAIN : fast_level;
  wire [3:0] next_term = {relay2_target, relay1_target, next_fast,
                          col_target};
  wire [3:0] term_now  = {RELAY_OUTPUT_TWO, RELAY_OUTPUT_ONE,
                          FAST_PULSE_TERMINAL, COLLECTOR_OUTPUT_ONE};

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire       ar_take  = ARVALID && ARREADY;
  wire [7:0] ar_ofs   = {ARADDR[7:2], 2'b00};
  wire [7:0] wr_ofs   = {aw_addr[7:2], 2'b00};
  wire       wr_fire  = aw_hold && w_hold && !BVALID;
  wire       wr_hit   = (wr_ofs <= `OFS_IRQ_MASK);
  wire       rd_hit   = (ar_ofs <= `OFS_IRQ_MASK);
  wire       lane0    = wr_fire && w_strb[0];
  wire       lanes01  = wr_fire && (w_strb[1:0] == 2'b11);
  wire       rd_clear = ar_take && (ar_ofs == `OFS_IRQ_STATUS);
  wire [3:0] next_irq_status = (irq_status & {4{!rd_clear}})
                               | (next_term ^ term_now);
  wire [31:0] rd_word =
    (ar_ofs == `OFS_FAST_TYPE)  ? {24'h000000, fast_type}  :
    (ar_ofs == `OFS_COL_SRC)    ? {24'h000000, col_src}    :
    (ar_ofs == `OFS_FAST_SRC)   ? {24'h000000, fast_src}   :
    (ar_ofs == `OFS_RELAY1_SRC) ? {24'h000000, relay1_src} :
    (ar_ofs == `OFS_RELAY2_SRC) ? {24'h000000, relay2_src} :
    (ar_ofs == `OFS_POLARITY)   ? {28'h0000000, polarity}  :
    (ar_ofs == `OFS_CARD_EN)    ? {24'h000000, card_en}    :
    (ar_ofs == `OFS_ON_DELAY)   ? {16'h0000, on_delay}     :
    (ar_ofs == `OFS_OFF_DELAY)  ? {16'h0000, off_delay}    :
    (ar_ofs == `OFS_TERM_STATE) ? {28'h0000000, term_now}  :
    (ar_ofs == `OFS_IRQ_STATUS) ? {28'h0000000, irq_status} :
    (ar_ofs == `OFS_IRQ_MASK)   ? {28'h0000000, irq_mask}  : 32'h00000000;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'b1;
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      AWREADY <= 1'b0;
      aw_hold <= 1'b1;
      aw_addr <= AWADDR;
    end else begin
      if (wr_fire) aw_hold <= 1'b0;
      if (BVALID && BREADY) AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WREADY <= 1'b1;
      w_hold <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (WVALID && WREADY) begin
      WREADY <= 1'b0;
      w_hold <= 1'b1;
      w_data <= WDATA;
      w_strb <= WSTRB;
    end else begin
      if (wr_fire) w_hold <= 1'b0;
      if (BVALID && BREADY) WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      BVALID <= 1'b0;
      BRESP  <= 2'b00;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP  <= wr_hit ? 2'b00 : 2'b10;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fast_type  <= `RST_FAST_TYPE;
      col_src    <= `RST_COL_SRC;
      fast_src   <= `RST_FAST_SRC;
      relay1_src <= `RST_RELAY1_SRC;
      relay2_src <= `RST_RELAY2_SRC;
      polarity   <= `RST_POLARITY;
      card_en    <= `RST_CARD_EN;
      irq_mask   <= 4'h0;
    end else if (lane0) begin
      if (wr_ofs == `OFS_FAST_TYPE)  fast_type  <= w_data[7:0];
      if (wr_ofs == `OFS_COL_SRC)    col_src    <= w_data[7:0];
      if (wr_ofs == `OFS_FAST_SRC)   fast_src   <= w_data[7:0];
      if (wr_ofs == `OFS_RELAY1_SRC) relay1_src <= w_data[7:0];
      if (wr_ofs == `OFS_RELAY2_SRC) relay2_src <= w_data[7:0];
      if (wr_ofs == `OFS_POLARITY)   polarity   <= w_data[3:0];
      if (wr_ofs == `OFS_CARD_EN)    card_en    <= w_data[7:0];
      if (wr_ofs == `OFS_IRQ_MASK)   irq_mask   <= w_data[3:0];
    end
  end

  // delays are clamped to the 50 s ceiling on write
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      on_delay  <= `RST_DELAY;
      off_delay <= `RST_DELAY;
    end else if (lanes01) begin
      if (wr_ofs == `OFS_ON_DELAY)  on_delay  <= clamp_ms(w_data[15:0]);
      if (wr_ofs == `OFS_OFF_DELAY) off_delay <= clamp_ms(w_data[15:0]);
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= 2'b00;
    end else if (ar_take) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_word;
      RRESP   <= rd_hit ? 2'b00 : 2'b10;
    end else if (RVALID && RREADY) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt: a change of any terminal sets its bit, set beats clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status <= 4'h0;
      IRQ        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      IRQ        <= |(next_irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // millisecond tick and index stretcher
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_W'(MS_TICK_CYCLES - 1)) begin
      ms_cnt  <= '0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + MS_W'(1);
      ms_tick <= 1'b0;
    end
  end

  // a fresh index pulse restarts the 10 ms window
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      index_cnt <= '0;
    end else if (INDEX_PULSE) begin
      index_cnt <= IDX_W'(INDEX_HOLD_CYCLES);
    end else if (index_active) begin
      index_cnt <= index_cnt - IDX_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // fast terminal switching delay
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fast_level <= 1'b0;
      dly_cnt    <= 16'h0000;
    end else if (fast_target == fast_level) begin
      dly_cnt <= 16'h0000;
    end else if (fast_hold_ms) begin
      fast_level <= fast_target;
      dly_cnt    <= 16'h0000;
    end else if (ms_tick) begin
      dly_cnt <= dly_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // terminal outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      COLLECTOR_OUTPUT_ONE <= 1'b0;
      FAST_PULSE_TERMINAL  <= 1'b0;
      RELAY_OUTPUT_ONE     <= 1'b0;
      RELAY_OUTPUT_TWO     <= 1'b0;
    end else begin
      COLLECTOR_OUTPUT_ONE <= next_term[`TERM_COL];
      FAST_PULSE_TERMINAL  <= next_term[`TERM_FAST];
      RELAY_OUTPUT_ONE     <= next_term[`TERM_RELAY1];
      RELAY_OUTPUT_TWO     <= next_term[`TERM_RELAY2];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence index_arrives;
    INDEX_PULSE && relay2_src == 8'h1b && !polarity[`TERM_RELAY2];
  endsequence

  sequence relay_two_held;
    RELAY_OUTPUT_TWO [*8];
  endsequence

  a_code_zero_off: assert property (
    col_src == 8'h00 && !polarity[`TERM_COL] |=> !COLLECTOR_OUTPUT_ONE)
    else $error("collector active with code zero");

  a_relay_running: assert property (
    relay1_src == 8'h01 && !polarity[`TERM_RELAY1]
    |-> ##1 RELAY_OUTPUT_ONE == $past(RUNNING))
    else $error("relay one does not follow running");

  a_card_gated: assert property (
    relay1_src >= 8'h29 && relay1_src <= 8'h2f && !card_on
    && !polarity[`TERM_RELAY1] |=> !RELAY_OUTPUT_ONE)
    else $error("card bit passed while card disabled");

  a_polarity_invert: assert property (
    col_src == 8'h05 && polarity[`TERM_COL]
    |=> COLLECTOR_OUTPUT_ONE == !$past(DRIVE_FAULT))
    else $error("polarity mask did not invert collector");

  a_index_stretch: assert property (
    index_arrives |=> ##1 relay_two_held)
    else $error("index output not held after pulse");

  a_index_release: assert property (
    index_cnt == IDX_W'(1) && !INDEX_PULSE |=> !index_active)
    else $error("index window did not close on time");

  a_fast_pulse_role: assert property (
    fast_type == 8'h00 |=> FAST_PULSE_TERMINAL == $past(PULSE_TRAIN))
    else $error("pulse role does not pass pulse train");

  a_same_code: assert property (
    col_src == relay1_src
    && polarity[`TERM_COL] == polarity[`TERM_RELAY1]
    |=> COLLECTOR_OUTPUT_ONE == RELAY_OUTPUT_ONE)
    else $error("shared code gives different terminals");

  a_dc_bus_level: assert property (
    relay2_src == 8'h1a && !polarity[`TERM_RELAY2]
    |=> RELAY_OUTPUT_TWO == $past(DC_BUS_ESTABLISHED))
    else $error("relay two does not follow dc bus");

  a_fast_no_delay: assert property (
    fast_type != 8'h00 && fast_target && !fast_level && on_delay == 16'h0000
    |=> fast_level ##1 FAST_PULSE_TERMINAL || fast_type == 8'h00)
    else $error("zero on delay not immediate");

endmodule : output_function_select

/* File: hdl/output_function_select_consts.svh */
`ifndef OUTPUT_FUNCTION_SELECT_CONSTS_SVH
`define OUTPUT_FUNCTION_SELECT_CONSTS_SVH

// register byte offsets
`define OFS_FAST_TYPE    8'h00
`define OFS_COL_SRC      8'h04
`define OFS_FAST_SRC     8'h08
`define OFS_RELAY1_SRC   8'h0c
`define OFS_RELAY2_SRC   8'h10
`define OFS_POLARITY     8'h14
`define OFS_CARD_EN      8'h18
`define OFS_ON_DELAY     8'h1c
`define OFS_OFF_DELAY    8'h20
`define OFS_TERM_STATE   8'h24
`define OFS_IRQ_STATUS   8'h28
`define OFS_IRQ_MASK     8'h2c

// reset values
`define RST_FAST_TYPE    8'h00
`define RST_COL_SRC      8'h00
`define RST_FAST_SRC     8'h00
`define RST_RELAY1_SRC   8'h01
`define RST_RELAY2_SRC   8'h05
`define RST_POLARITY     4'h0
`define RST_CARD_EN      8'h00
`define RST_DELAY        16'h0000

// terminal bit positions in polarity, state and interrupt words
`define TERM_COL         0
`define TERM_FAST        1
`define TERM_RELAY1      2
`define TERM_RELAY2      3

// timing
`define CLK_HZ           50000000
`define MS_TICK_CYC      (`CLK_HZ / 1000)
`define INDEX_HOLD_MS    10
`define INDEX_HOLD_CYC   (`INDEX_HOLD_MS * `MS_TICK_CYC)
`define DELAY_MAX_MS     16'hc350
`endif

/* File: hdl/output_function_select_pkg.sv */
package output_function_select_pkg;
  typedef logic [7:0]  func_code_t;
  typedef logic [15:0] delay_ms_t;
  typedef logic [3:0]  term_vec_t;
  typedef enum logic [0:0] {
    FAST_PULSE  = 1'b0,
    FAST_SWITCH = 1'b1
  } fast_role_t;
endpackage : output_function_select_pkg

/* File: verif/output_function_select_bench.sv */
`timescale 1ns/100ps
module output_function_select_bench;
  // ----------------------------------------
  // stimulus, design and load
  // ----------------------------------------
  localparam logic [63:0] BASE_ON = 64'h0000_0017_ffdf_fffe;
  localparam logic [63:0] CARD_ON = 64'h0000_fe00_0000_0000;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [1:0]  resp;
  logic [63:0] src, on;
  logic [31:0] rst_tab [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h5};
  wire  logic  awready, wready, bvalid, arready, rvalid, irq, y1, hd, r1, r2;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          error_cnt, samples_checked, edge_cnt, base, n;
  output_function_select #(.MS_TICK_CYCLES(5), .INDEX_HOLD_CYCLES(40))
    u_output_function_select (
    .CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .RUNNING(src[1]),
    .FORWARD_RUNNING(src[2]), .REVERSE_RUNNING(src[3]), .JOGGING(src[4]),
    .DRIVE_FAULT(src[5]), .FREQ_LEVEL_DETECT_ONE(src[6]),
    .FREQ_LEVEL_DETECT_TWO(src[7]), .FREQ_REACHED(src[8]),
    .ZERO_SPEED_RUNNING(src[9]), .UPPER_LIMIT(src[10]),
    .LOWER_LIMIT(src[11]), .READY_TO_RUN(src[12]),
    .PRE_EXCITING(src[13]), .OVERLOAD_PREALARM(src[14]),
    .UNDERLOAD_PREALARM(src[15]), .SEQ_STAGE_DONE(src[16]),
    .SEQ_CYCLE_DONE(src[17]), .COUNT_SET_REACHED(src[18]),
    .COUNT_DESIGNATED_REACHED(src[19]), .EXTERNAL_FAULT(src[20]),
    .RUN_TIME_REACHED(src[22]), .SERIAL_VIRTUAL_BIT(src[23]),
    .FIELDBUS_VIRTUAL_BIT(src[24]), .ETHERNET_VIRTUAL_BIT(src[25]),
    .DC_BUS_ESTABLISHED(src[26]), .INDEX_PULSE(src[27]),
    .PULSE_SUPERPOSITION(src[28]), .SAFE_TORQUE_OFF_FAULT(src[29]),
    .POSITIONING_DONE(src[30]), .SPINDLE_ZEROING_DONE(src[31]),
    .SPINDLE_DIVISION_DONE(src[32]), .SPEED_LIMITED(src[33]),
    .INDUSTRIAL_ETH_VIRTUAL_BIT(src[34]), .CONTROL_SWITCH_DONE(src[36]),
    .CARD_COLLECTOR_ONE(src[41]), .CARD_COLLECTOR_TWO(src[42]),
    .CARD_FAST_TERMINAL(src[43]), .CARD_RELAY_ONE(src[44]),
    .CARD_RELAY_TWO(src[45]), .CARD_RELAY_THREE(src[46]),
    .CARD_RELAY_FOUR(src[47]), .PULSE_TRAIN(src[63]),
    .COLLECTOR_OUTPUT_ONE(y1), .FAST_PULSE_TERMINAL(hd),
    .RELAY_OUTPUT_ONE(r1), .RELAY_OUTPUT_TWO(r2), .IRQ(irq));
  terminal_load_model u_terminal_load_model (
    .clk(clk), .rstn(rstn), .fast_line(hd), .edge_cnt(edge_cnt));
  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rdr
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic test_done;
    $display("checked %0d wrong %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, src} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdr(8'(4 * i));
      chk(rd, rst_tab[i]);
    end
    rdr(8'h30);
    chk(resp, 2'b10);
    wr(8'h30, 32'h1);
    chk(resp, 2'b10);
    $display("reset and map test done");
    wr(8'h00, 32'h1);
    for (int k = 0; k < 128; k++) begin
      if (k == 64) wr(8'h18, 32'h1);
      for (int i = 1; i < 5; i++) wr(8'(4 * i), 32'(k % 64));
      src <= 64'h1 << (k % 64);
      settle();
      on = (BASE_ON | (k > 63 ? CARD_ON : 64'h0)) >> (k % 64);
      chk({r2, r1, hd, y1}, {4{on[0]}});
      @(posedge clk);
      src <= '0;
      repeat (50) @(posedge clk);
      chk({r2, r1, hd, y1}, 4'h0);
    end
    $display("code table test done");
    rdr(8'h28);
    wr(8'h14, 32'hf);
    settle();
    chk({r2, r1, hd, y1}, 4'hf);
    chk(irq, 1'b0);
    wr(8'h2c, 32'hf);
    settle();
    chk(irq, 1'b1);
    rdr(8'h28);
    chk(rd, 32'hf);
    settle();
    chk(irq, 1'b0);
    $display("polarity and interrupt test done");
    wr(8'h14, 32'h0);
    wr(8'h10, 32'd27);
    src[27] <= 1'b1;
    @(posedge clk);
    src[27] <= 1'b0;
    n = 0;
    repeat (60) begin
      @(posedge clk);
      if (r2 === 1'b1) n++;
    end
    chk(n, 40);
    wr(8'h00, 32'h0);
    base = edge_cnt;
    repeat (3) begin
      @(posedge clk);
      src[63] <= 1'b1;
      repeat (2) @(posedge clk);
      src[63] <= 1'b0;
      @(posedge clk);
    end
    settle();
    chk(edge_cnt - base, 3);
    $display("index and pulse test done");
    wr(8'h1c, 32'hffff);
    rdr(8'h1c);
    chk(rd, 32'hc350);
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h1);
    wr(8'h1c, 32'h2);
    src[1] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(hd, 1'b0);
    repeat (14) @(posedge clk);
    chk(hd, 1'b1);
    $display("switching delay test done");
    test_done();
  end
endmodule : output_function_select_bench

/* File: verif/terminal_load_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// load on the fast terminal: counts pulses
// ----------------------------------------
module terminal_load_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic fast_line,
  output var  int   edge_cnt
);
  logic last;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last     <= 1'b0;
      edge_cnt <= 0;
    end else begin
      last <= fast_line;
      if (fast_line && !last) edge_cnt <= edge_cnt + 1;
    end
  end
endmodule : terminal_load_model
